// ==== logic/cpu_timing_params.svh ====
`ifndef CPU_TIMING_PARAMS_SVH
`define CPU_TIMING_PARAMS_SVH

// instruction word field holding the operation byte
`define OPC_MSB          15
`define OPC_LSB          8

// widths of cycle counts and the state total
`define CNT_W            8
`define STATES_W         16

// per-cycle state costs, on-chip memory unless noted
`define S_FETCH          5'h02
`define S_BRANCH_ADDR    5'h02
`define S_STACK          5'h02
`define S_BYTE_MEM       5'h02
`define S_BYTE_PERIPH_F  5'h02
`define S_BYTE_PERIPH_S  5'h03
`define S_WORD_MEM       5'h02
`define S_INTERNAL       5'h01

`endif

// ==== logic/cpu_timing_pkg.sv ====
`default_nettype none
package cpu_timing_pkg;

	typedef enum logic [15:0] {
		OPC_NOP    = 16'h0001,
		OPC_SLEEP  = 16'h0002,
		OPC_CCR    = 16'h0004,
		OPC_ARITH  = 16'h0008,
		OPC_LOGIC  = 16'h0010,
		OPC_SHIFT  = 16'h0020,
		OPC_BRANCH = 16'h0040,
		OPC_MULDIV = 16'h0080,
		OPC_FLOW   = 16'h0100,
		OPC_BIT    = 16'h0200,
		OPC_MOVE   = 16'h0400,
		OPC_BLKMOV = 16'h0800,
		OPC_DECADJ = 16'h1000,
		OPC_UNDEF  = 16'h2000
	} op_class_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_DONE = 2'b10
	} seq_state_t;

endpackage
`default_nettype wire

// ==== logic/cpu_opcode_and_state_timing.sv ====
// Function
// - operation class from instruction bits 15..8
// - push and pop decode as plain moves
// - states are weighted sum of six cycle counts
// - fetch from on-chip memory costs two states
// - internal operation cycle costs one state
// - peripheral byte access costs two or three
`include "cpu_timing_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_opcode_and_state_timing (
	input  wire logic                           ref_clk,
	input  wire logic                           reset_n,
	input  wire logic                           instr_valid,
	input  wire logic [15:0]                    instr_word,
	input  wire logic [`CNT_W-1:0]              fetch_cnt,
	input  wire logic [`CNT_W-1:0]              branch_addr_cnt,
	input  wire logic [`CNT_W-1:0]              stack_cnt,
	input  wire logic [`CNT_W-1:0]              byte_cnt,
	input  wire logic [`CNT_W-1:0]              word_cnt,
	input  wire logic [`CNT_W-1:0]              internal_cnt,
	input  wire logic                           byte_to_periph,
	input  wire logic                           periph_slow,
	output logic                                result_valid_q,
	output cpu_timing_pkg::op_class_t           op_class_q,
	output logic [`STATES_W-1:0]                exec_states_q
);
	import cpu_timing_pkg::*;

	// ------------------------------------------------------------
	// operation decode
	// ------------------------------------------------------------
	logic [7:0]   opc;
	op_class_t    op_class_d;

	assign opc = instr_word[`OPC_MSB:`OPC_LSB];

	always_comb begin
		op_class_d = OPC_UNDEF;
		case (opc[7:4])
			4'h0: begin
				case (opc[3:0])
					4'h0: op_class_d = OPC_NOP;
					4'h1: op_class_d = OPC_SLEEP;
					4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: op_class_d = OPC_CCR;
					4'h8, 4'h9, 4'ha, 4'hb, 4'he: op_class_d = OPC_ARITH;
					4'hc, 4'hd: op_class_d = OPC_MOVE;
					4'hf: op_class_d = OPC_DECADJ;
					default: op_class_d = OPC_UNDEF;
				endcase
			end
			4'h1: begin
				case (opc[3:0])
					4'h0, 4'h1, 4'h2, 4'h3: op_class_d = OPC_SHIFT;
					4'h4, 4'h5, 4'h6, 4'h7: op_class_d = OPC_LOGIC;
					4'hf: op_class_d = OPC_DECADJ;
					default: op_class_d = OPC_ARITH;
				endcase
			end
			4'h2, 4'h3: op_class_d = OPC_MOVE;
			4'h4: op_class_d = OPC_BRANCH;
			4'h5: begin
				case (opc[3:0])
					4'h0, 4'h1: op_class_d = OPC_MULDIV;
					4'h4, 4'h5, 4'h6, 4'h9, 4'ha, 4'hb, 4'hd, 4'he, 4'hf:
						op_class_d = OPC_FLOW;
					default: op_class_d = OPC_UNDEF;
				endcase
			end
			// 6c/6d carry stack push and pop, decoded as moves
			4'h6: op_class_d = opc[3] ? OPC_MOVE : OPC_BIT;
			4'h7: begin
				case (opc[3:0])
					4'h9: op_class_d = OPC_MOVE;
					4'hb: op_class_d = OPC_BLKMOV;
					4'h8, 4'ha: op_class_d = OPC_UNDEF;
					default: op_class_d = OPC_BIT;
				endcase
			end
			4'h8, 4'h9, 4'ha, 4'hb: op_class_d = OPC_ARITH;
			4'hc, 4'hd, 4'he: op_class_d = OPC_LOGIC;
			4'hf: op_class_d = OPC_MOVE;
			default: op_class_d = OPC_UNDEF;
		endcase
	end

	// ------------------------------------------------------------
	// state cost accumulation
	// ------------------------------------------------------------
	logic [4:0]             byte_cost;
	logic [`STATES_W-1:0]   exec_states_d;

	// peripheral wait class decided by the address decoder upstream
	assign byte_cost = byte_to_periph ?
		(periph_slow ? `S_BYTE_PERIPH_S : `S_BYTE_PERIPH_F)
		: `S_BYTE_MEM;

	// counts are 8 bits and costs 5 bits, so the sum cannot overflow 16 bits;
	// operands are widened first so that no product is cut to 8 bits
	assign exec_states_d =
		`STATES_W'(fetch_cnt) * `STATES_W'(`S_FETCH) +
		`STATES_W'(branch_addr_cnt) * `STATES_W'(`S_BRANCH_ADDR) +
		`STATES_W'(stack_cnt) * `STATES_W'(`S_STACK) +
		`STATES_W'(byte_cnt) * `STATES_W'(byte_cost) +
		`STATES_W'(word_cnt) * `STATES_W'(`S_WORD_MEM) +
		`STATES_W'(internal_cnt) * `STATES_W'(`S_INTERNAL);

	// ------------------------------------------------------------
	// result registers
	// ------------------------------------------------------------
	seq_state_t seq_q;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			seq_q <= ST_IDLE;
		end else begin
			case (seq_q)
				ST_IDLE: seq_q <= instr_valid ? ST_DONE : ST_IDLE;
				ST_DONE: seq_q <= instr_valid ? ST_DONE : ST_IDLE;
				default: seq_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			result_valid_q <= 1'b0;
		end else begin
			result_valid_q <= instr_valid;
		end
	end

	// results hold their last value between instructions
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			op_class_q    <= OPC_NOP;
			exec_states_q <= 16'h0000;
		end else if (instr_valid) begin
			op_class_q    <= op_class_d;
			exec_states_q <= exec_states_d;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	opbyte_decode_a: assert property (
		instr_valid && instr_word[15:8] == 8'h00 |=> op_class_q == OPC_NOP)
		else $error("opcode 00 not decoded as nop");

	pushpop_as_move_a: assert property (
		instr_valid && instr_word[15:9] == 7'h36 |=> op_class_q == OPC_MOVE)
		else $error("push/pop encoding not decoded as move");

	total_sum_a: assert property (
		instr_valid && byte_cnt == 8'h00 |=> exec_states_q ==
		$past(2 * fetch_cnt + 2 * branch_addr_cnt + 2 * stack_cnt
		+ 2 * word_cnt + internal_cnt))
		else $error("state total is not the weighted sum");

	fetch_cost_a: assert property (
		instr_valid && fetch_cnt == 8'h03 && branch_addr_cnt == 8'h00
		&& stack_cnt == 8'h00 && byte_cnt == 8'h00 && word_cnt == 8'h00
		&& internal_cnt == 8'h00 |=> exec_states_q == 16'h0006)
		else $error("fetch cost is not two states");

	internal_cost_a: assert property (
		instr_valid && internal_cnt == 8'h05 && fetch_cnt == 8'h00
		&& branch_addr_cnt == 8'h00 && stack_cnt == 8'h00
		&& byte_cnt == 8'h00 && word_cnt == 8'h00
		|=> exec_states_q == 16'h0005)
		else $error("internal cost is not one state");

	periph_cost_a: assert property (
		instr_valid && byte_to_periph && fetch_cnt == 8'h00
		&& branch_addr_cnt == 8'h00 && stack_cnt == 8'h00
		&& word_cnt == 8'h00 && internal_cnt == 8'h00
		|=> exec_states_q == $past(byte_cnt) * ($past(periph_slow) ? 16'h0003 : 16'h0002))
		else $error("peripheral byte cost wrong");

	mem_cost_a: assert property (
		instr_valid && !byte_to_periph && fetch_cnt == 8'h00
		&& internal_cnt == 8'h00 |=> exec_states_q == 2 * $past(branch_addr_cnt)
		+ 2 * $past(stack_cnt) + 2 * $past(byte_cnt) + 2 * $past(word_cnt))
		else $error("memory cycle cost is not two states");

	hold_result_a: assert property (
		!instr_valid |=> $stable(exec_states_q) && !result_valid_q)
		else $error("result changed without an instruction");

	// a taken instruction must show its result on the very next edge
	valid_pulse_a: assert property (
		instr_valid |=> result_valid_q)
		else $error("result valid missing after an instruction");

	// downstream logic relies on exactly one class bit being set
	class_onehot_a: assert property (
		$onehot(op_class_q))
		else $error("operation class is not one-hot");

	back_to_back_c: cover property (instr_valid [*3]);
	slow_periph_c: cover property (instr_valid && byte_to_periph && periph_slow);
	fast_periph_c: cover property (instr_valid && byte_to_periph && !periph_slow);
	branch_decode_c: cover property (instr_valid ##1 op_class_q == OPC_BRANCH);

endmodule

`default_nettype wire

// ==== tb/periph_map.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// peripheral module speed map
// ---------------------------------------------
// each module answers in two or three states; which one is fixed per module
module periph_map #(
	parameter logic [3:0] SLOW_MASK = 4'ha
) (
	input  wire logic [1:0] module_sel,
	output logic            slow
);
	assign slow = SLOW_MASK[module_sel];
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cpu_timing_pkg::*;
	localparam logic [3:0] SLOW_MASK = 4'ha;
	logic        ref_clk     = 1'b0;
	logic        reset_n     = 1'b0;
	logic        instr_valid = 1'b0;
	logic [15:0] instr_word  = 16'h0000;
	logic [7:0]  c_q [6]     = '{default: 8'h00};
	logic        to_periph   = 1'b0;
	logic [1:0]  module_sel  = 2'h0;
	logic        slow;
	logic        rv;
	op_class_t   cls;
	logic [15:0] states;
	int          n_fail      = 0;
	int          cmp_count   = 0;
	always #10 ref_clk = ~ref_clk;
	periph_map #(.SLOW_MASK(SLOW_MASK)) PM (.module_sel(module_sel), .slow(slow));
	cpu_opcode_and_state_timing DUT (.ref_clk(ref_clk), .reset_n(reset_n),
		.instr_valid(instr_valid), .instr_word(instr_word), .fetch_cnt(c_q[0]),
		.branch_addr_cnt(c_q[1]), .stack_cnt(c_q[2]), .byte_cnt(c_q[3]),
		.word_cnt(c_q[4]), .internal_cnt(c_q[5]), .byte_to_periph(to_periph),
		.periph_slow(slow), .result_valid_q(rv), .op_class_q(cls), .exec_states_q(states));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// ---------------------------------------------
	// one instruction, valid for a single edge
	// ---------------------------------------------
	task automatic issue(input logic [15:0] w, input logic [7:0] f, j, k, l, m, n,
		input logic p, input logic [1:0] s);
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr_word  <= w;
		c_q         <= '{f, j, k, l, m, n};
		to_periph   <= p;
		module_sel  <= s;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		#1;
		check("valid", {15'h0, rv}, 16'h0001);
	endtask
	task automatic test_reset();
		check("class", cls, OPC_NOP);
		check("states", states, 16'h0000);
		check("valid", {15'h0, rv}, 16'h0000);
	endtask
	task automatic test_decode();
		logic [15:0] w [8] = '{16'h00ff, 16'h01aa, 16'h6d76, 16'h6f70, 16'h4012, 16'h8005,
			16'h5034, 16'h7b5c};
		op_class_t   e [8] = '{OPC_NOP, OPC_SLEEP, OPC_MOVE, OPC_MOVE, OPC_BRANCH, OPC_ARITH,
			OPC_MULDIV, OPC_BLKMOV};
		for (int i = 0; i < 8; i++) begin
			issue(w[i], 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 2'h0);
			check("class", cls, e[i]);
		end
		@(posedge ref_clk);
		#1;
		check("valid", {15'h0, rv}, 16'h0000);
		check("class", cls, OPC_BLKMOV);
	endtask
	// ---------------------------------------------
	// weighted sums: set operand, memory, peripheral
	// ---------------------------------------------
	task automatic test_timing();
		issue(16'h7d00, 8'h02, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 1'b0, 2'h1);
		check("states", states, 16'h0008);
		issue(16'h5f00, 8'h02, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 1'b0, 2'h0);
		check("states", states, 16'h0008);
		issue(16'h6900, 8'h01, 8'h00, 8'h00, 8'h00, 8'h03, 8'h05, 1'b0, 2'h0);
		check("states", states, 16'h000d);
		issue(16'h0000, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 1'b0, 2'h0);
		check("states", states, 16'h0af5);
		issue(16'h0000, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 2'h0);
		check("states", states, 16'h0006);
		issue(16'h0000, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 1'b0, 2'h0);
		check("states", states, 16'h0005);
		issue(16'h0000, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 1'b0, 2'h0);
		check("states", states, 16'h0008);
		for (int s = 0; s < 4; s++) begin
			issue(16'h0000, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 1'b1, 2'(s));
			check("states", states, SLOW_MASK[s] ? 16'h0009 : 16'h0006);
		end
		for (int s = 0; s < 4; s++) begin
			issue(16'h7e00, 8'h02, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 1'b1, 2'(s));
			check("states", states, SLOW_MASK[s] ? 16'h000d : 16'h000a);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		#1;
		test_reset();
		test_decode();
		test_timing();
		report_and_stop();
	end
	// generous bound: the sequence needs well under a hundred cycles
	initial begin
		#20000;
		n_fail++;
		report_and_stop();
	end
endmodule
`default_nettype wire
